// ---- rtl/kps_pkg.sv ----
// What this block does
// - set column mask bit stops that column detecting
// - column mask at 03H, bits 0-5, rest zero
// - host mode waits for start command
// - start command clears both results, starts debounce
// - up to three keys, fields 4:0, 9:5, 14:10
// - zero field means no key, unused fields zero
// - all fields zero means nothing pressed
// - over four keys: error bit, fields 31
// - first column-masked, second also per-key masked
// - reading a result register clears it
// - results at 00H and 01H, error bit 15
// - key number is five times column-1 plus row
// - control bit picks automatic or host start
// - after debounce load results, release irq, hold
// - result read during hold restarts hold time
// - detection rearms only on read after hold
package kps_pkg;

    localparam int NUM_COLS = 6;
    localparam int NUM_ROWS = 5;
    localparam int NUM_KEYS = 30;
    localparam int KEY_W    = 5;
    localparam int REG_W    = 16;
    localparam int ADDR_W   = 5;
    localparam int COUNT_W  = 3;

    // *****************************************************
    // register map
    // *****************************************************
    localparam logic [4:0] ADDR_SCAN_RESULT   = 5'h00;
    localparam logic [4:0] ADDR_STATUS_RESULT = 5'h01;
    localparam logic [4:0] ADDR_COLUMN_MASK   = 5'h03;
    localparam logic [4:0] ADDR_SCAN_START    = 5'h04;
    localparam logic       PAGE_DATA          = 1'h0;
    localparam logic       PAGE_CTRL          = 1'h1;

    localparam int ERR_BIT = 15;
    localparam logic [4:0]  KEY_ERROR_CODE    = 5'h1F;
    localparam logic [4:0]  KEY_NONE          = 5'h00;
    localparam logic [2:0]  ERROR_COUNT       = 3'h4;
    localparam logic [2:0]  COUNT_SAT         = 3'h5;
    localparam logic [5:0]  COLUMN_MASK_RESET = 6'h00;
    localparam logic [15:0] RESULT_RESET      = 16'h0000;

    // *****************************************************
    // timing
    // *****************************************************
    localparam int CLK_FREQ_KHZ     = 25000;
    localparam int DEBOUNCE_TIME_US = 1000;
    localparam int HOLD_TIME_US     = 100;
    localparam int DEBOUNCE_CYCLES  =
        (DEBOUNCE_TIME_US * CLK_FREQ_KHZ + 999) / 1000;
    localparam int HOLD_CYCLES      =
        (HOLD_TIME_US * CLK_FREQ_KHZ + 999) / 1000;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic        page;
        logic [4:0]  addr;
        logic [15:0] wdata;
    } kps_reg_req_type;

    typedef struct packed {
        logic [4:0] third;
        logic [4:0] second;
        logic [4:0] first;
    } kps_keys_type;

    typedef enum logic [4:0] {
        ST_IDLE      = 5'h01,
        ST_WAIT_HOST = 5'h02,
        ST_DEBOUNCE  = 5'h04,
        ST_HOLD      = 5'h08,
        ST_REARM     = 5'h10
    } kps_state_type;

endpackage

// ---- rtl/kps_encode.sv ----
`timescale 1ns/10ps
module kps_encode
    import kps_pkg::*;
#(
    parameter int N_KEYS = NUM_KEYS
) (
    input  wire logic [N_KEYS-1:0]  keys_in,
    output kps_keys_type            keys_out,
    output logic [COUNT_W-1:0]      count_out
);

    // *****************************************************
    // priority pack of pressed keys
    // *****************************************************
    always_comb begin
        logic [COUNT_W-1:0] n;
        n = '0;
        keys_out = '{third: KEY_NONE, second: KEY_NONE,
                     first: KEY_NONE};
        // lowest key number fills the lowest field
        for (int i = 0; i < N_KEYS; i++) begin
            if (keys_in[i]) begin
                if (n == 3'h0) begin
                    keys_out.first = KEY_W'(i + 1);
                end else if (n == 3'h1) begin
                    keys_out.second = KEY_W'(i + 1);
                end else if (n == 3'h2) begin
                    keys_out.third = KEY_W'(i + 1);
                end
                if (n != COUNT_SAT) begin
                    n = n + 3'h1;
                end
            end
        end
        count_out = n;
    end

endmodule

// ---- rtl/kps_top.sv ----
`timescale 1ns/10ps
module kps_top
    import kps_pkg::*;
#(
    parameter int DEBOUNCE_CYCLES_P = DEBOUNCE_CYCLES,
    parameter int HOLD_CYCLES_P     = HOLD_CYCLES
) (
    input  wire logic                CLK_SYS,
    input  wire logic                RST_B,
    input  wire logic [NUM_KEYS-1:0] KEY_PRESS,
    input  wire logic [NUM_KEYS-1:0] PER_KEY_MASK,
    input  wire logic                HOST_START_SELECT,
    input  wire logic                KEY_IRQ_DISABLE,
    input  kps_reg_req_type          REG_REQ,
    output logic [REG_W-1:0]         REG_RDATA,
    output logic                     REG_RVALID,
    output logic                     KEY_IRQ_N_A,
    output logic [4:0]               SCANNER_STATE
);

    localparam int CNT_MAX = (DEBOUNCE_CYCLES_P > HOLD_CYCLES_P) ?
                             DEBOUNCE_CYCLES_P : HOLD_CYCLES_P;
    localparam int CNT_W   = $clog2(CNT_MAX + 1);

    // *****************************************************
    // declarations
    // *****************************************************
    logic [NUM_KEYS-1:0] key_meta_r;
    logic [NUM_KEYS-1:0] key_sync_r;
    logic [NUM_KEYS-1:0] col_en;
    logic [NUM_KEYS-1:0] scan_vec;
    logic [NUM_KEYS-1:0] status_vec;
    logic [5:0]          col_mask_r;
    logic [15:0]         scan_res_r;
    logic [15:0]         status_res_r;
    logic [15:0]         scan_word;
    logic [15:0]         status_word;
    logic [15:0]         rdata_nxt;
    logic [15:0]         rdata_r;
    logic                rvalid_r;
    logic                irq_n_r;
    logic [CNT_W-1:0]    cnt_r;
    logic                cnt_clr;
    kps_state_type       state_r;
    kps_state_type       state_nxt;
    kps_keys_type        scan_keys;
    kps_keys_type        status_keys;
    logic [COUNT_W-1:0]  scan_count;
    logic [COUNT_W-1:0]  status_count;
    logic                press_any;
    logic                scan_err;
    logic                start_cmd;
    logic                mask_wr;
    logic                rd_scan;
    logic                rd_status;
    logic                rd_any;
    logic                deb_done;
    logic                hold_done;
    logic                hold_restart;
    logic                load_pulse;

    // *****************************************************
    // key pin synchroniser
    // *****************************************************
    always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
            key_meta_r <= '0;
            key_sync_r <= '0;
        end else begin
            key_meta_r <= KEY_PRESS;
            key_sync_r <= key_meta_r;
        end
    end

    // *****************************************************
    // key filtering
    // *****************************************************
    for (genvar c = 0; c < NUM_COLS; c++) begin : g_col
        assign col_en[c*NUM_ROWS +: NUM_ROWS] =
            {NUM_ROWS{~col_mask_r[c]}};
    end

    assign scan_vec   = key_sync_r & col_en;
    assign status_vec = scan_vec & ~PER_KEY_MASK;
    assign press_any  = |scan_vec;

    kps_encode #(
        .N_KEYS    (NUM_KEYS)
    ) u_enc_scan (
        .keys_in   (scan_vec),
        .keys_out  (scan_keys),
        .count_out (scan_count)
    );

    kps_encode #(
        .N_KEYS    (NUM_KEYS)
    ) u_enc_status (
        .keys_in   (status_vec),
        .keys_out  (status_keys),
        .count_out (status_count)
    );

    // the error decision is taken on the column-masked set so
    // that both registers flag it together
    assign scan_err = scan_count > ERROR_COUNT;
    assign scan_word = scan_err ?
        {1'h1, {3{KEY_ERROR_CODE}}} : {1'h0, scan_keys};
    assign status_word = scan_err ?
        {1'h1, {3{KEY_ERROR_CODE}}} : {1'h0, status_keys};

    // *****************************************************
    // register access decode
    // *****************************************************
    assign start_cmd = REG_REQ.wr && REG_REQ.page == PAGE_CTRL &&
                       REG_REQ.addr == ADDR_SCAN_START;
    assign mask_wr   = REG_REQ.wr && REG_REQ.page == PAGE_CTRL &&
                       REG_REQ.addr == ADDR_COLUMN_MASK;
    assign rd_scan   = REG_REQ.rd && REG_REQ.page == PAGE_DATA &&
                       REG_REQ.addr == ADDR_SCAN_RESULT;
    assign rd_status = REG_REQ.rd && REG_REQ.page == PAGE_DATA &&
                       REG_REQ.addr == ADDR_STATUS_RESULT;
    assign rd_any    = rd_scan || rd_status;

    always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
            col_mask_r <= COLUMN_MASK_RESET;
        end else if (mask_wr) begin
            col_mask_r <= REG_REQ.wdata[5:0];
        end
    end

    // *****************************************************
    // scan sequencer
    // *****************************************************
    assign deb_done  = cnt_r == CNT_W'(DEBOUNCE_CYCLES_P - 1);
    assign hold_done = cnt_r == CNT_W'(HOLD_CYCLES_P - 1);
    assign hold_restart = state_r == ST_HOLD && rd_any;
    assign load_pulse   = state_r == ST_DEBOUNCE && deb_done;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE: begin
                if (press_any) begin
                    state_nxt = HOST_START_SELECT ?
                        ST_WAIT_HOST : ST_DEBOUNCE;
                end
            end
            ST_WAIT_HOST: begin
                if (start_cmd) begin
                    state_nxt = ST_DEBOUNCE;
                end
            end
            ST_DEBOUNCE: begin
                if (deb_done) begin
                    state_nxt = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (!rd_any && hold_done) begin
                    state_nxt = ST_REARM;
                end
            end
            ST_REARM: begin
                if (rd_any) begin
                    state_nxt = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // one counter serves both debounce and hold; it restarts on
    // every state change
    assign cnt_clr = state_nxt != state_r || hold_restart;

    always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
            cnt_r <= '0;
        end else if (cnt_clr) begin
            cnt_r <= '0;
        end else if (cnt_r != CNT_W'(CNT_MAX)) begin
            cnt_r <= cnt_r + CNT_W'(1);
        end
    end

    // *****************************************************
    // result registers
    // *****************************************************
    // a fresh load wins over a clearing read in the same cycle
    always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
            scan_res_r <= RESULT_RESET;
        end else if (load_pulse) begin
            scan_res_r <= scan_word;
        end else if (start_cmd || rd_scan) begin
            scan_res_r <= RESULT_RESET;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
            status_res_r <= RESULT_RESET;
        end else if (load_pulse) begin
            status_res_r <= status_word;
        end else if (start_cmd || rd_status) begin
            status_res_r <= RESULT_RESET;
        end
    end

    // *****************************************************
    // read data and outputs
    // *****************************************************
    always_comb begin
        rdata_nxt = RESULT_RESET;
        if (rd_scan) begin
            rdata_nxt = scan_res_r;
        end else if (rd_status) begin
            rdata_nxt = status_res_r;
        end else if (REG_REQ.page == PAGE_CTRL &&
                     REG_REQ.addr == ADDR_COLUMN_MASK) begin
            rdata_nxt = {10'h000, col_mask_r};
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
            rdata_r  <= RESULT_RESET;
            rvalid_r <= 1'h0;
        end else begin
            rdata_r  <= REG_REQ.rd ? rdata_nxt : RESULT_RESET;
            rvalid_r <= REG_REQ.rd;
        end
    end

    // irq is low while a press waits for or is in debounce
    always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
            irq_n_r <= 1'h1;
        end else begin
            irq_n_r <= KEY_IRQ_DISABLE ||
                !(state_nxt == ST_WAIT_HOST ||
                  state_nxt == ST_DEBOUNCE);
        end
    end

    assign REG_RDATA     = rdata_r;
    assign REG_RVALID    = rvalid_r;
    assign KEY_IRQ_N_A   = irq_n_r;
    assign SCANNER_STATE = state_r;

    // *****************************************************
    // assertions
    // *****************************************************
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_B);

    a_column_mask_blocks: assert property (
        state_r == ST_IDLE && !(|(key_sync_r & col_en))
        |=> state_r == ST_IDLE)
        else $error("masked or absent key left idle");

    a_mask_readback: assert property (
        REG_REQ.rd && REG_REQ.page == PAGE_CTRL &&
        REG_REQ.addr == ADDR_COLUMN_MASK
        |=> REG_RDATA == {10'h000, $past(col_mask_r)})
        else $error("column mask read back wrong");

    a_host_mode_waits: assert property (
        state_r == ST_IDLE && press_any && HOST_START_SELECT
        |=> state_r == ST_WAIT_HOST && !SCANNER_STATE[2])
        else $error("host mode did not wait for command");

    a_auto_mode_starts: assert property (
        state_r == ST_IDLE && press_any && !HOST_START_SELECT
        |=> state_r == ST_DEBOUNCE)
        else $error("key press mode did not start debounce");

    a_start_clears: assert property (
        start_cmd && !load_pulse
        |=> scan_res_r == RESULT_RESET &&
            status_res_r == RESULT_RESET)
        else $error("start command did not clear results");

    a_error_fill: assert property (
        load_pulse && scan_count > ERROR_COUNT
        |=> scan_res_r[ERR_BIT] && status_res_r[ERR_BIT] &&
            scan_res_r[4:0] == KEY_ERROR_CODE &&
            status_res_r[14:10] == KEY_ERROR_CODE)
        else $error("too many keys not flagged");

    a_single_key_low: assert property (
        load_pulse && scan_count == 3'h1
        |=> scan_res_r[14:5] == 10'h000 &&
            scan_res_r[4:0] != KEY_NONE)
        else $error("single key not in first field");

    a_read_clears: assert property (
        rd_scan && !load_pulse
        |=> REG_RDATA == $past(scan_res_r) &&
            scan_res_r == RESULT_RESET)
        else $error("scan result not cleared by read");

    a_irq_release: assert property (
        load_pulse |=> KEY_IRQ_N_A && state_r == ST_HOLD)
        else $error("irq not released after debounce");

    a_hold_restart: assert property (
        hold_restart |=> cnt_r == '0 && state_r == ST_HOLD)
        else $error("hold not restarted by read");

    a_rearm_needs_read: assert property (
        state_r == ST_REARM && !rd_any |=> state_r == ST_REARM)
        else $error("detection rearmed without read");

endmodule

// ---- verification/kps_host_model.sv ----
`timescale 1ns/10ps
module kps_host_model
    import kps_pkg::*;
(
    input  wire logic             clk,
    input  wire logic [REG_W-1:0] rdata,
    input  wire logic             rvalid,
    output kps_reg_req_type       req,
    output logic                  got_valid
);
    initial req = '0;
    initial got_valid = 1'b0;

    // one-cycle strobe; data of a start command is never looked at
    task automatic access(input logic w, input logic pg,
                          input logic [4:0] a, input logic [15:0] d,
                          output logic [15:0] q);
        @(posedge clk);
        #1;
        req = '{wr: w, rd: !w, page: pg, addr: a, wdata: d};
        @(posedge clk);
        #1;
        req = '0;
        q = rdata;
        got_valid = rvalid;
    endtask
endmodule

// ---- verification/tb_kps_top.sv ----
`timescale 1ns/10ps
module tb_kps_top;
    import kps_pkg::*;
    // short counts keep the run small
    localparam int DBN = 20;
    localparam int HOLD_TIME_SELECT = 10;

    logic                clk_sys   = 1'b0;
    logic                rst_b     = 1'b0;
    logic [29:0]         key_press = '0;
    logic [29:0]         pk_mask   = '0;
    logic                host_sel  = 1'b0;
    logic                irq_dis   = 1'b0;
    kps_reg_req_type     reg_req;
    logic [REG_W-1:0]    reg_rdata;
    logic                reg_rvalid;
    logic                irq_n;
    logic [4:0]          state;
    logic                got_valid;
    int                  err_count = 0;
    int                  n_tests   = 0;
    logic [15:0]         q;
    logic [29:0]         tk [7];
    logic [29:0]         tp [7];
    logic [5:0]          tc [7];

    always #20 clk_sys = ~clk_sys;

    kps_top #(.DEBOUNCE_CYCLES_P(DBN), .HOLD_CYCLES_P(HOLD_TIME_SELECT)) uut (
        .CLK_SYS(clk_sys), .RST_B(rst_b), .KEY_PRESS(key_press),
        .PER_KEY_MASK(pk_mask), .HOST_START_SELECT(host_sel),
        .KEY_IRQ_DISABLE(irq_dis), .REG_REQ(reg_req),
        .REG_RDATA(reg_rdata), .REG_RVALID(reg_rvalid),
        .KEY_IRQ_N_A(irq_n), .SCANNER_STATE(state)
    );

    kps_host_model host (
        .clk(clk_sys), .rdata(reg_rdata), .rvalid(reg_rvalid),
        .req(reg_req), .got_valid(got_valid)
    );

    // ****************************************
    // helpers
    // ****************************************
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rd(input logic pg, input logic [4:0] a,
                      input logic [15:0] exp);
        logic [15:0] d;
        host.access(1'b0, pg, a, 16'h0000, d);
        check({15'h0000, got_valid}, 16'h0001);
        check(d, exp);
    endtask

    task automatic wr(input logic pg, input logic [4:0] a,
                      input logic [15:0] d);
        host.access(1'b1, pg, a, d, q);
    endtask

    task automatic wait_st(input logic [4:0] st, input int max);
        int i;
        i = 0;
        while (state !== st && i < max) begin
            @(posedge clk_sys);
            #1;
            i++;
        end
        check({11'h000, state}, {11'h000, st});
    endtask

    // first three unmasked keys, lowest number first
    function automatic logic [15:0] exp_word(input logic [29:0] k,
            input logic [5:0] cm, input logic [29:0] pk);
        logic [4:0] f [3] = '{default: 5'h00};
        int n = 0;
        int c = 0;
        for (int i = 0; i < 30; i++) begin
            if (k[i] && !cm[i/5]) begin
                n++;
                if (!pk[i] && c < 3) begin
                    f[c] = 5'(i + 1);
                    c++;
                end
            end
        end
        return (n > 4) ? 16'hFFFF : {1'b0, f[2], f[1], f[0]};
    endfunction

    task automatic finish_scan;
        wait_st(ST_HOLD, DBN + 2);
        key_press = '0;
        @(posedge clk_sys);
        #1;
        check({15'h0000, irq_n}, 16'h0001);
        wait_st(ST_REARM, HOLD_TIME_SELECT + 2);
        repeat (5) @(posedge clk_sys);
        #1;
        check({11'h000, state}, {11'h000, ST_REARM});
    endtask

    task automatic run_scan(input logic [29:0] k, input logic [29:0] pk,
                            input logic [5:0] cm);
        pk_mask = pk;
        key_press = k;
        wait_st(ST_DEBOUNCE, 10);
        check({15'h0000, irq_n}, {15'h0000, irq_dis});
        finish_scan();
        rd(1'b0, ADDR_SCAN_RESULT, exp_word(k, cm, '0));
        rd(1'b0, ADDR_STATUS_RESULT, exp_word(k, cm, pk));
        rd(1'b0, ADDR_SCAN_RESULT, 16'h0000);
        rd(1'b0, ADDR_STATUS_RESULT, 16'h0000);
    endtask

    task automatic final_report;
        if (err_count == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        #(40 * 20000);
        err_count++;
        final_report();
    end

    // ****************************************
    // tests
    // ****************************************
    initial begin
        tk = '{30'h0000_0001, 30'h2000_0020, 30'h0200_0410,
               30'h2000_0043, 30'h0000_001F, 30'h0000_005F,
               30'h3E00_0000};
        tp = '{30'h0000_0000, 30'h0000_0000, 30'h0000_0400,
               30'h0000_0000, 30'h0000_0000, 30'h0000_0000,
               30'h3FFF_FFFF};
        tc = '{6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h01, 6'h00};
        repeat (6) @(posedge clk_sys);
        #1;
        rst_b = 1'b1;
        rd(1'b1, ADDR_COLUMN_MASK, 16'h0000);
        rd(1'b0, ADDR_SCAN_RESULT, 16'h0000);
        wr(1'b1, ADDR_COLUMN_MASK, 16'hFFFF);
        rd(1'b1, ADDR_COLUMN_MASK, 16'h003F);
        key_press = 30'h3FFF_FFFF;
        repeat (10) @(posedge clk_sys);
        #1;
        check({11'h000, state}, {11'h000, ST_IDLE});
        check({15'h0000, irq_n}, 16'h0001);
        key_press = '0;
        rd(1'b1, 5'h05, 16'h0000);
        wr(1'b0, ADDR_SCAN_RESULT, 16'h1234);
        rd(1'b0, ADDR_SCAN_RESULT, 16'h0000);
        // single, pair, per-key masked, four, error, column mask, error with all keys per-key masked
        for (int i = 0; i < 7; i++) begin
            wr(1'b1, ADDR_COLUMN_MASK, {10'h000, tc[i]});
            irq_dis = (i == 2);
            run_scan(tk[i], tp[i], tc[i]);
        end
        irq_dis = 1'b0;
        pk_mask = '0;
        // reads inside hold keep restarting it
        key_press = 30'h0000_0002;
        wait_st(ST_DEBOUNCE, 10);
        wait_st(ST_HOLD, DBN + 2);
        key_press = '0;
        // first read returns the loaded word, later ones the cleared word
        for (int j = 0; j < 3; j++) begin
            repeat (4) @(posedge clk_sys);
            rd(1'b0, ADDR_STATUS_RESULT,
               (j == 0) ? 16'h0002 : 16'h0000);
        end
        check({11'h000, state}, {11'h000, ST_HOLD});
        wait_st(ST_REARM, HOLD_TIME_SELECT + 2);
        rd(1'b0, ADDR_SCAN_RESULT, 16'h0002);
        // leave a stale status word, then run a host started scan
        key_press = 30'h0000_0004;
        wait_st(ST_DEBOUNCE, 10);
        finish_scan();
        rd(1'b0, ADDR_SCAN_RESULT, 16'h0003);
        host_sel = 1'b1;
        key_press = 30'h0000_0008;
        wait_st(ST_WAIT_HOST, 10);
        check({15'h0000, irq_n}, 16'h0000);
        repeat (DBN + 5) @(posedge clk_sys);
        #1;
        check({11'h000, state}, {11'h000, ST_WAIT_HOST});
        wr(1'b1, ADDR_SCAN_START, 16'hA5C3);
        check({11'h000, state}, {11'h000, ST_DEBOUNCE});
        rd(1'b0, ADDR_STATUS_RESULT, 16'h0000);
        finish_scan();
        rd(1'b0, ADDR_SCAN_RESULT, 16'h0004);
        rd(1'b0, ADDR_STATUS_RESULT, 16'h0004);
        final_report();
    end
endmodule
